// File: core/fts_cycle_decode.sv
// Cycle decoder and storage of a flow-through burst SRAM with late write.
// Assumes the memory controller drives the synchronous pins on ref_clk;
// sleep, output enable and burst order are asynchronous and synchronised here.
`timescale 1ns/10ps
`include "fts_defines.svh"

// What this block does
// - State changes only at rising clock edges.
// - Inactive select deselects; advance then continues deselect.
// - Selected, load, read: latch address, start read.
// - Advance in read burst steps address, ignores pins.
// - Selected, load, write, any lane: start write.
// - Advance in write burst steps, writes chosen lanes.
// - Low lanes written; all high aborts write.
// - Bus driven only on read with enable low.
// - Sleep forces data pins to high impedance.
// - Never drive data in deselect or write.
// - Clock enable high holds every register except the synchronisers.
// - Sleep entry and exit take two cycles.
// - Linear or interleaved four-beat burst order.
module fts_cycle_decode import fts_pkg::*; (
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     reset_n,
    // Synchronous controls
    input  wire logic                     select_low_first_n,
    input  wire logic                     select_high_second,
    input  wire logic                     select_low_third_n,
    input  wire logic                     advance_load,
    input  wire logic                     write_enable_n,
    input  wire logic [`FTS_LANES-1:0]    byte_lane_write_n,
    input  wire logic                     clock_enable_n,
    input  wire logic [`FTS_ADDR_W-1:0]   address,
    // Asynchronous controls
    input  wire logic                     output_enable_n,
    input  wire logic                     sleep_request,
    input  wire logic                     burst_order_select,
    // Data bus split into three signals
    input  wire logic [`FTS_DATA_W-1:0]   data_in,
    output logic      [`FTS_DATA_W-1:0]   data_out,
    output logic                          data_oe,
    // Status
    output fts_cycle_type                 cycle_kind,
    output logic      [`FTS_ADDR_W-1:0]   current_address,
    output logic                          sleep_active
);

    // Burst low address bits for a given beat
    function automatic logic [`FTS_BEAT_W-1:0] burst_lsb(
        input logic [`FTS_BEAT_W-1:0] start,
        input logic [`FTS_BEAT_W-1:0] beat,
        input logic                   interleave
    );
        burst_lsb = interleave ? (start ^ beat) : (start + beat);
    endfunction

    logic [`FTS_DATA_W-1:0]  mem [0:`FTS_DEPTH-1];
    logic [`FTS_SYNC_W-1:0]  sync1_q;
    logic [`FTS_SYNC_W-1:0]  sync2_q;
    fts_state_type           state_q;
    fts_state_type           state_d;
    fts_cycle_type           cycle_q;
    fts_cycle_type           cycle_d;
    logic [`FTS_ADDR_W-1:0]  addr_q;
    logic [`FTS_ADDR_W-1:0]  addr_d;
    logic [`FTS_BEAT_W-1:0]  start_q;
    logic [`FTS_BEAT_W-1:0]  beat_q;
    logic [`FTS_BEAT_W-1:0]  beat_d;
    logic                    wr_pend_q;
    logic [`FTS_ADDR_W-1:0]  wr_addr_q;
    logic [`FTS_LANES-1:0]   wr_lanes_q;
    logic [`FTS_DATA_W-1:0]  data_out_q;
    logic                    load;
    logic                    hold;
    logic                    selected;
    logic                    sleep_s;
    logic                    oe_n_s;
    logic                    order_s;
    logic                    read_active;

    // Two-flop synchronisers; only stage two feeds logic
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {burst_order_select, output_enable_n, sleep_request};
            sync2_q <= sync1_q;
        end
    end

    // Sync stages give the two-cycle sleep entry and wake-up for free
    assign sleep_s  = sync2_q[`FTS_SYN_SLEEP];
    assign oe_n_s   = sync2_q[`FTS_SYN_OE];
    assign order_s  = sync2_q[`FTS_SYN_ORDER];
    assign selected = ~select_low_first_n & select_high_second & ~select_low_third_n;
    // Sleep preserves state exactly like a suspended clock
    assign hold     = clock_enable_n | sleep_s;

    // Decode of the sampled controls
    always_comb begin
        state_d = state_q;
        cycle_d = FTS_CYC_DESELECT;
        load    = 1'b0;
        if (!advance_load) begin
            if (!selected) begin
                state_d = FTS_ST_DESEL;
                cycle_d = FTS_CYC_DESELECT;
            end else if (write_enable_n) begin
                load    = 1'b1;
                state_d = FTS_ST_READ;
                cycle_d = oe_n_s ? FTS_CYC_DUMMY : FTS_CYC_READ;
            end else begin
                load    = 1'b1;
                state_d = FTS_ST_WRITE;
                cycle_d = (&byte_lane_write_n) ? FTS_CYC_ABORT : FTS_CYC_WRITE;
            end
        end else begin
            unique case (state_q)
                FTS_ST_DESEL: cycle_d = FTS_CYC_DESELECT;
                FTS_ST_READ:  cycle_d = oe_n_s ? FTS_CYC_DUMMY : FTS_CYC_READ;
                FTS_ST_WRITE: cycle_d = (&byte_lane_write_n) ? FTS_CYC_ABORT
                                                             : FTS_CYC_WRITE;
            endcase
        end
    end

    // Next address: external on load, burst step on advance
    always_comb begin
        beat_d = load ? `FTS_BEAT_FIRST : beat_q + `FTS_BEAT_STEP;
        if (load) begin
            addr_d = address;
        end else if (advance_load && state_q != FTS_ST_DESEL) begin
            addr_d = {addr_q[`FTS_ADDR_W-1:`FTS_HI_LSB],
                      burst_lsb(start_q, beat_d, order_s)};
        end else begin
            addr_d = addr_q;
        end
    end

    // Cycle state, only on accepted rising edges
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= FTS_ST_DESEL;
            cycle_q <= FTS_CYC_DESELECT;
            addr_q  <= '0;
            start_q <= `FTS_BEAT_FIRST;
            beat_q  <= `FTS_BEAT_FIRST;
        end else if (!hold) begin
            state_q <= state_d;
            cycle_q <= cycle_d;
            addr_q  <= addr_d;
            beat_q  <= (load || advance_load) ? beat_d : beat_q;
            if (load) begin
                start_q <= address[`FTS_LSB_HI:0];
            end
        end
    end

    // Late write bookkeeping; data follows one accepted edge later
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_pend_q  <= 1'b0;
            wr_addr_q  <= '0;
            wr_lanes_q <= '0;
        end else if (!hold) begin
            wr_pend_q  <= (cycle_d == FTS_CYC_WRITE);
            wr_addr_q  <= addr_d;
            wr_lanes_q <= ~byte_lane_write_n;
        end
    end

    // Array write of the lanes chosen one edge before
    always_ff @(posedge ref_clk) begin
        if (reset_n && !hold && wr_pend_q) begin
            for (int i = 0; i < `FTS_LANES; i++) begin
                if (wr_lanes_q[i]) begin
                    mem[wr_addr_q][i*`FTS_LANE_W +: `FTS_LANE_W] <=
                        data_in[i*`FTS_LANE_W +: `FTS_LANE_W];
                end
            end
        end
    end

    // Flow-through read: data of the new address in the same cycle.
    // No bypass: reading an address whose late write is still pending
    // returns the old word.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_out_q <= '0;
        end else if (!hold && (cycle_d == FTS_CYC_READ || cycle_d == FTS_CYC_DUMMY)) begin
            data_out_q <= mem[addr_d];
        end
    end

    // Bus drive follows the live enable and sleep, not the edge values
    assign read_active     = (cycle_q == FTS_CYC_READ) || (cycle_q == FTS_CYC_DUMMY);
    assign data_oe         = read_active & ~oe_n_s & ~sleep_s;
    assign data_out        = data_out_q;
    assign cycle_kind      = cycle_q;
    assign current_address = addr_q;
    assign sleep_active    = sleep_s;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    hold_regs_a: assert property (hold |=> $stable(addr_q) && $stable(state_q))
        else $error("registers moved while held");
    deselect_a: assert property (!hold && !advance_load && !selected
        |=> cycle_q == FTS_CYC_DESELECT && state_q == FTS_ST_DESEL)
        else $error("inactive select did not deselect");
    read_load_a: assert property (!hold && !advance_load && selected && write_enable_n
        |=> addr_q == $past(address) && read_active)
        else $error("read did not latch address");
    read_step_a: assert property (!hold && advance_load && state_q == FTS_ST_READ
        |=> addr_q[`FTS_ADDR_W-1:`FTS_HI_LSB] == $past(addr_q[`FTS_ADDR_W-1:`FTS_HI_LSB])
            && read_active && addr_q[`FTS_LSB_HI:0] != $past(addr_q[`FTS_LSB_HI:0]))
        else $error("read burst did not step");
    write_load_a: assert property (!hold && !advance_load && selected && !write_enable_n
        && !(&byte_lane_write_n) |=> cycle_q == FTS_CYC_WRITE && wr_pend_q
        && addr_q == $past(address))
        else $error("write did not start");
    abort_a: assert property (!hold && state_q == FTS_ST_WRITE && advance_load
        && (&byte_lane_write_n) |=> cycle_q == FTS_CYC_ABORT && !wr_pend_q)
        else $error("all lanes high did not abort");
    drive_a: assert property (data_oe |-> !sleep_s && !oe_n_s && read_active)
        else $error("bus driven without read and enable");
    sleep_z_a: assert property (sleep_s |-> !data_oe)
        else $error("bus driven in sleep");
    no_drive_a: assert property (!read_active |-> !data_oe)
        else $error("bus driven outside read");
    sleep_in_a: assert property ($rose(sleep_request) |-> ##1 !$rose(sleep_s) ##1 sleep_s)
        else $error("sleep entry not two cycles");
    sleep_out_a: assert property ($fell(sleep_request) |-> ##2 !sleep_s)
        else $error("wake-up not two cycles");

    burst_read_c:  cover property ((cycle_q == FTS_CYC_READ)[*4]);
    burst_write_c: cover property ((cycle_q == FTS_CYC_WRITE)[*4] ##1 !wr_pend_q);
    dummy_c:       cover property (cycle_q == FTS_CYC_DUMMY);
    sleep_c:       cover property (sleep_s ##1 !sleep_s);

endmodule

// File: core/fts_defines.svh
// Sizes and fixed counts of the flow-through burst SRAM cycle decoder.
// Assumes it is included by bare name from the package and the core module.
`ifndef FTS_DEFINES_SVH
`define FTS_DEFINES_SVH

`define FTS_ADDR_W     18
`define FTS_LANES      4
`define FTS_LANE_W     9
`define FTS_DATA_W     36
`define FTS_DEPTH      262144
`define FTS_BEAT_W     2
`define FTS_BEAT_STEP  2'h1
`define FTS_BEAT_FIRST 2'h0
`define FTS_LSB_HI     1
`define FTS_HI_LSB     2
`define FTS_SYNC_W     3
`define FTS_SYN_SLEEP  0
`define FTS_SYN_OE     1
`define FTS_SYN_ORDER  2

`endif

// File: core/fts_pkg.sv
// Types shared by the cycle decoder and whatever binds to it.
// Assumes fts_defines.svh is on the include path.
`include "fts_defines.svh"

package fts_pkg;

    // Kind of cycle decoded at the last accepted clock edge
    typedef enum logic [2:0] {
        FTS_CYC_DESELECT,
        FTS_CYC_READ,
        FTS_CYC_DUMMY,
        FTS_CYC_WRITE,
        FTS_CYC_ABORT
    } fts_cycle_type;

    // Burst context that an advance continues
    typedef enum logic [1:0] {
        FTS_ST_DESEL,
        FTS_ST_READ,
        FTS_ST_WRITE
    } fts_state_type;

endpackage

// File: test/fts_host_model.sv
// Host memory controller model that drives every input pin of the cycle decoder except ref_clk and reset_n.
// Assumes its tasks are called in the time step of a rising ref_clk edge.
`timescale 1ns/10ps
`include "fts_defines.svh"
module fts_host_model import fts_pkg::*; (
    // Clock
    input  wire logic                   ref_clk,
    // Synchronous pins
    output logic                        select_low_first_n,
    output logic                        select_high_second,
    output logic                        select_low_third_n,
    output logic                        advance_load,
    output logic                        write_enable_n,
    output logic [`FTS_LANES-1:0]       byte_lane_write_n,
    output logic                        clock_enable_n,
    output logic [`FTS_ADDR_W-1:0]      address,
    output logic [`FTS_DATA_W-1:0]      data_in,
    // Asynchronous pins
    output logic                        output_enable_n,
    output logic                        sleep_request,
    output logic                        burst_order_select
);
    logic                   burst_wr;
    logic                   pend;
    logic [`FTS_DATA_W-1:0] pend_data;

    // Quiet bus at time zero: deselected, enabled, awake, linear order
    initial begin
        {select_low_first_n, select_high_second, select_low_third_n} = 3'h5;
        {advance_load, write_enable_n, clock_enable_n} = 3'h2;
        byte_lane_write_n = 4'hF;
        address = 18'h00000;
        data_in = 36'h000000000;
        {output_enable_n, sleep_request, burst_order_select} = 3'h0;
        {burst_wr, pend} = 2'h0;
        pend_data = 36'h000000000;
    end

    // One command per edge; burst_wr is updated only on a load or deselect, an advance keeps it
    task automatic cmd(input logic [2:0] sel, input logic step, input logic we_n,
                       input logic [3:0] lanes, input logic [17:0] addr,
                       input logic [35:0] wd);
        @(posedge ref_clk);
        select_low_first_n <= !sel[0];
        select_high_second <= sel[1];
        select_low_third_n <= !sel[2];
        advance_load       <= step;
        write_enable_n     <= we_n;
        byte_lane_write_n  <= lanes;
        address            <= addr;
        clock_enable_n     <= 1'b0;
        // Idle bus shows the inverse, so stale data never passes for new
        data_in <= pend ? pend_data : ~data_in;
        if (!step)
            burst_wr = (sel == 3'h7) && !we_n;
        pend      = burst_wr && (lanes != 4'hF);
        pend_data = wd;
    endtask

    // Clock enable high for n edges while the pins change underneath
    task automatic hold(input int n);
        @(posedge ref_clk);
        clock_enable_n <= 1'b1;
        advance_load   <= 1'b1;
        address        <= ~address;
        repeat (n - 1) @(posedge ref_clk);
    endtask

    // Asynchronous pins, changed in the caller's edge time step
    task automatic set_async(input logic oe_n, input logic slp, input logic ord);
        output_enable_n    <= oe_n;
        sleep_request      <= slp;
        burst_order_select <= ord;
    endtask
endmodule

// File: test/tb_top.sv
// Self-checking bench for the cycle decoder, driven by the host model.
// Assumes the package and the host model are compiled before this file.
`timescale 1ns/10ps
`include "fts_defines.svh"
module tb_top import fts_pkg::*;;
    logic                   ref_clk = 1'b0;
    logic                   reset_n = 1'b0;
    logic                   s1_n, s2, s3_n, advance, we_n, ce_n, oe_n, slp, ord, doe, slp_act;
    logic [`FTS_LANES-1:0]  lanes;
    logic [`FTS_ADDR_W-1:0] addr, cur;
    logic [`FTS_DATA_W-1:0] din, dout;
    fts_cycle_type          kind;
    int                     errors = 0;
    int                     num_checks = 0;
    logic [`FTS_DATA_W-1:0] mem_exp [4];
    localparam logic [17:0] BASE = 18'h2A5F6;

    always #4 ref_clk = ~ref_clk;

    fts_cycle_decode i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .select_low_first_n(s1_n), .select_high_second(s2), .select_low_third_n(s3_n),
        .advance_load(advance), .write_enable_n(we_n), .byte_lane_write_n(lanes),
        .clock_enable_n(ce_n), .address(addr), .output_enable_n(oe_n),
        .sleep_request(slp), .burst_order_select(ord), .data_in(din),
        .data_out(dout), .data_oe(doe), .cycle_kind(kind), .current_address(cur),
        .sleep_active(slp_act));
    fts_host_model i_host (.ref_clk(ref_clk), .select_low_first_n(s1_n),
        .select_high_second(s2), .select_low_third_n(s3_n), .advance_load(advance),
        .write_enable_n(we_n), .byte_lane_write_n(lanes), .clock_enable_n(ce_n),
        .address(addr), .data_in(din), .output_enable_n(oe_n),
        .sleep_request(slp), .burst_order_select(ord));

    task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    task automatic des();
        i_host.cmd(3'h0, 1'b0, 1'b1, 4'hF, BASE, '0);
    endtask
    task automatic rload();
        i_host.cmd(3'h7, 1'b0, 1'b1, 4'hF, BASE, '0);
    endtask

    // Load then three advances with selects and address scrambled
    task automatic burst(input logic rd, input logic il, input logic [1:0] st);
        logic [17:0] a;
        logic [1:0]  b;
        logic [1:0]  nb;
        a = {BASE[17:2], st};
        i_host.cmd(3'h7, 1'b0, rd, 4'h0, a, mem_exp[st]);
        for (int k = 0; k < 4; k++) begin
            b = il ? st ^ 2'(k) : st + 2'(k);
            nb = il ? st ^ 2'(k + 1) : st + 2'(k + 1);
            if (k < 3)
                i_host.cmd(3'h0, 1'b1, 1'b1, 4'h0, ~a, mem_exp[nb]);
            else
                des();
            #1;
            chk(kind, rd ? FTS_CYC_READ : FTS_CYC_WRITE, "burst kind");
            chk(cur, {a[17:2], b}, "burst address");
            chk(doe, rd, "bus drive");
            if (rd)
                chk(dout, mem_exp[b], "read data");
        end
        $display("burst rd=%0b il=%0b done", rd, il);
    endtask

    // Partial lane write, load abort, advance abort, then read both beats back
    task automatic t_lanes();
        i_host.cmd(3'h7, 1'b0, 1'b0, 4'hE, BASE, 36'hFFFFFFFFF);
        i_host.cmd(3'h7, 1'b0, 1'b0, 4'hF, BASE, 36'h000000000);
        i_host.cmd(3'h0, 1'b1, 1'b0, 4'hF, ~BASE, 36'h000000000);
        #1 chk(kind, FTS_CYC_ABORT, "abort kind");
        des();
        #1 chk(kind, FTS_CYC_ABORT, "advance abort kind");
        mem_exp[2][8:0] = 9'h1FF;
        rload();
        i_host.cmd(3'h0, 1'b1, 1'b1, 4'h0, ~BASE, '0);
        #1 chk(dout, mem_exp[2], "lane data");
        des();
        #1 chk(dout, mem_exp[3], "abort left data");
        $display("lanes done");
    endtask

    // Each select alone inactive, then advance continues the deselect
    task automatic t_desel();
        for (int i = 0; i < 3; i++) begin
            rload();
            i_host.cmd(3'h7 ^ (3'h1 << i), 1'b0, 1'b1, 4'hF, BASE, '0);
            i_host.cmd(3'h0, 1'b1, 1'b1, 4'h0, ~BASE, '0);
            #1 chk(kind, FTS_CYC_DESELECT, "deselect");
            chk(doe, 1'b0, "deselect drive");
            des();
            #1 chk(kind, FTS_CYC_DESELECT, "continue deselect");
        end
        $display("deselect done");
    endtask

    // Output enable, clock enable and sleep
    task automatic t_async();
        des();
        i_host.set_async(1'b1, 1'b0, 1'b0);
        des();
        rload();
        des();
        i_host.set_async(1'b0, 1'b0, 1'b0);
        #1 chk(kind, FTS_CYC_DUMMY, "dummy read");
        chk(doe, 1'b0, "dummy drive");
        // Enable needs two edges through the synchroniser before the load
        des();
        rload();
        i_host.hold(2);
        des();
        #1 chk(cur, BASE, "hold address");
        chk(kind, FTS_CYC_READ, "hold kind");
        chk(doe, 1'b1, "read drive");
        des();
        i_host.set_async(1'b0, 1'b1, 1'b0);
        rload();
        #1 chk(slp_act, 1'b0, "sleep early");
        des();
        #1 chk(slp_act, 1'b1, "sleep entry");
        chk(doe, 1'b0, "sleep drive");
        des();
        i_host.set_async(1'b0, 1'b0, 1'b0);
        des();
        #1 chk(kind, FTS_CYC_READ, "sleep state kept");
        des();
        #1 chk(slp_act, 1'b0, "sleep exit");
        chk(doe, 1'b1, "wake drive");
        des();
        #1 chk(kind, FTS_CYC_DESELECT, "resumed");
        $display("async done");
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 4; i++)
            mem_exp[i] = 36'hC3C3C3C30 + 36'(i);
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        #1 chk(kind, FTS_CYC_DESELECT, "reset kind");
        burst(1'b0, 1'b0, 2'h2);
        burst(1'b1, 1'b0, 2'h2);
        t_lanes();
        t_desel();
        des();
        i_host.set_async(1'b0, 1'b0, 1'b1);
        des();
        burst(1'b1, 1'b1, 2'h1);
        t_async();
        conclude();
    end

    // Hang guard
    initial begin
        #100000;
        errors++;
        $display("Error at %0t: run limit reached", $time);
        conclude();
    end
endmodule
